// *** ctd_consts.vh ***
`ifndef CTD_CONSTS_VH
`define CTD_CONSTS_VH

// Clock
`define CTD_CLK_NS 50

// Filter and timeout times in ns (least times, rounded up to cycles)
`define CTD_TXD_TIMEOUT_NS 1000000
`define CTD_BUS_DOM_TIMEOUT_NS 1000000
`define CTD_LOCAL_WAKE_FILTER_NS 40000
`define CTD_BUS_WAKE_FILTER_NS 4000
`define CTD_LOGIC_UV_FILTER_NS 100000
`define CTD_SLEEP_HOLD_NS 50000
`define CTD_RX_CLAMP_NS 10000
`define CTD_SHORT_NS 10000

// Same times as 16-bit cycle counts at the 50 ns clock
`define CTD_TXD_TIMEOUT_CYC 16'h4E20
`define CTD_BUS_DOM_TIMEOUT_CYC 16'h4E20
`define CTD_LOCAL_WAKE_FILTER_CYC 16'h0320
`define CTD_BUS_WAKE_FILTER_CYC 16'h0050
`define CTD_LOGIC_UV_FILTER_CYC 16'h07D0
`define CTD_SLEEP_HOLD_CYC 16'h03E8
`define CTD_RX_CLAMP_CYC 16'h00C8
`define CTD_SHORT_CYC 16'h00C8

// Edge counts
`define CTD_EDGE_LIMIT 3'h4

// Register map
`define CTD_CTRL_OFF 8'h00
`define CTD_STATUS_OFF 8'h04
`define CTD_CTRL_TXEN_BIT 0
`define CTD_CTRL_RESET 32'h00000001

// Status fields
`define CTD_ST_MODE_LSB 0
`define CTD_ST_PWRUP_BIT 3
`define CTD_ST_WAKE_BIT 4
`define CTD_ST_WSRC_BIT 5
`define CTD_ST_BUSF_BIT 6
`define CTD_ST_LOCF_BIT 7
`define CTD_ST_LUV_BIT 8
`define CTD_ST_BUV_BIT 9
`define CTD_ST_TXBLK_BIT 10
`define CTD_ST_OTBLK_BIT 11

`endif

// *** ctd_filter.v ***
`timescale 1ns/1ns
// Persistence filter: hit goes high once cond has held longer than LIMIT cycles
module ctd_filter #(
	parameter W = 16,
	parameter [W-1:0] LIMIT = 16'h0010
) (
	input wire clk,
	input wire rst_n,
	input wire cond,
	output reg hit
);
	reg [W-1:0] cnt_q;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= {W{1'b0}};
			hit <= 1'b0;
		end else if (!cond) begin
			cnt_q <= {W{1'b0}};
			hit <= 1'b0;
		end else begin
			if (cnt_q != LIMIT)
				cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
			hit <= (cnt_q == LIMIT);
		end
	end
endmodule

// *** ctd_mode_diag.v ***
// Behaviour
// - Filtered wake sets wake flag; cleared entering receive-only or normal
// - Normal mode: low error flag means local wake or bus failure
// - Wake source cleared after four edges or exit
// - Four failed dominant cycles set bus failure
// - Bus failure cleared on normal entry, four good
// - Local failure shown receive-only; clear conditions
// - Transmit dominant timeout blocks transmitter, flags failure
// - Receive pin clamped high flags failure, blocks
// - Receive/transmit short blocks transmitter, flags failure
// - Bus dominant timeout only flags local failure
// - Overtemperature blocks until next transmit dominant bit
// - Both wake pin edges count as wake
// - Filtered logic undervoltage forces sleep, internal flag
// - Battery undervoltage forces standby, internal flag
// - Normal: error high if clean, receive follows bus
// - Receive-only: error low on power-up or failure
// - Low-power modes: both outputs show pending wake
// - Two pins select the operating mode
// - Held go-to-sleep enters sleep after hold time
// - Inhibit driven except in sleep, then floats
// - Power-up flag shown receive-only, cleared entering normal
`timescale 1ns/1ns
`include "ctd_consts.vh"
module ctd_mode_diag #(
	parameter [15:0] TXD_TIMEOUT_CYC = `CTD_TXD_TIMEOUT_CYC,
	parameter [15:0] BUS_DOM_TIMEOUT_CYC = `CTD_BUS_DOM_TIMEOUT_CYC,
	parameter [15:0] LOCAL_WAKE_FILTER_CYC = `CTD_LOCAL_WAKE_FILTER_CYC,
	parameter [15:0] BUS_WAKE_FILTER_CYC = `CTD_BUS_WAKE_FILTER_CYC,
	parameter [15:0] LOGIC_UV_FILTER_CYC = `CTD_LOGIC_UV_FILTER_CYC,
	parameter [15:0] SLEEP_HOLD_CYC = `CTD_SLEEP_HOLD_CYC,
	parameter [15:0] RX_CLAMP_CYC = `CTD_RX_CLAMP_CYC,
	parameter [15:0] SHORT_CYC = `CTD_SHORT_CYC
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire mode_ctrl_hi,
	input wire standby_n_ctrl,
	input wire tx_in,
	input wire rx_pin_in,
	input wire bus_dominant_in,
	input wire local_wake_in,
	input wire overtemp_in,
	input wire logic_uv_in,
	input wire battery_uv_in,
	output reg rx_out,
	output reg error_flag_out,
	output reg bus_drive_out,
	output reg split_en_out,
	output reg regulator_inhibit_out,
	output reg regulator_inhibit_oe
);
	localparam [2:0] M_NORMAL = 3'h0;
	localparam [2:0] M_RECEIVE_ONLY_MODE = 3'h1;
	localparam [2:0] M_STANDBY = 3'h2;
	localparam [2:0] M_GOSLEEP = 3'h3;
	localparam [2:0] M_SLEEP = 3'h4;

	reg [2:0] mode_q;
	reg [2:0] mode_d;
	reg pwr_up_q;
	reg wake_q;
	reg wake_src_q;
	reg bus_fail_q;
	reg loc_fail_q;
	reg luv_q;
	reg buv_q;
	reg tx_blk_q;
	reg ot_blk_q;
	reg ot_seen_q;
	reg tx_q;
	reg wk_ref_q;
	reg [2:0] src_edges_q;
	reg [2:0] fail_cnt_q;
	reg [2:0] ok_cnt_q;
	reg dom_seen_q;
	reg in_bit_q;
	reg txen_q;
	wire tx_timeout;
	wire bus_dom_timeout;
	wire local_wake_hit;
	wire bus_wake_hit;
	wire logic_uv_hit;
	wire sleep_hold_hit;
	wire rx_clamp_hit;
	wire short_hit;
	wire low_power;
	wire r2d;
	wire d2r;
	wire enter_normal;
	wire rx_to_normal;
	wire wake_ev;
	wire rx_int;
	wire drive_ok;
	wire bit_fail;

	////////////////////////////////////////////////////////////////////////
	// Filters and timeouts
	ctd_filter #(.W(16), .LIMIT(TXD_TIMEOUT_CYC)) u_txd_to (
		.clk(pclk), .rst_n(presetn), .cond(mode_q == M_NORMAL && !tx_in),
		.hit(tx_timeout));
	ctd_filter #(.W(16), .LIMIT(BUS_DOM_TIMEOUT_CYC)) u_bus_to (
		.clk(pclk), .rst_n(presetn), .cond(bus_dominant_in), .hit(bus_dom_timeout));
	ctd_filter #(.W(16), .LIMIT(LOCAL_WAKE_FILTER_CYC)) u_lwk (
		.clk(pclk), .rst_n(presetn), .cond(local_wake_in != wk_ref_q),
		.hit(local_wake_hit));
	ctd_filter #(.W(16), .LIMIT(BUS_WAKE_FILTER_CYC)) u_bwk (
		.clk(pclk), .rst_n(presetn), .cond(low_power && bus_dominant_in),
		.hit(bus_wake_hit));
	ctd_filter #(.W(16), .LIMIT(LOGIC_UV_FILTER_CYC)) u_luv (
		.clk(pclk), .rst_n(presetn), .cond(logic_uv_in), .hit(logic_uv_hit));
	ctd_filter #(.W(16), .LIMIT(SLEEP_HOLD_CYC)) u_hold (
		.clk(pclk), .rst_n(presetn), .cond(mode_q == M_GOSLEEP),
		.hit(sleep_hold_hit));
	ctd_filter #(.W(16), .LIMIT(RX_CLAMP_CYC)) u_clamp (
		.clk(pclk), .rst_n(presetn), .cond(!rx_out && rx_pin_in),
		.hit(rx_clamp_hit));
	ctd_filter #(.W(16), .LIMIT(SHORT_CYC)) u_short (
		.clk(pclk), .rst_n(presetn), .cond(rx_out && !rx_pin_in && !tx_in),
		.hit(short_hit));

	////////////////////////////////////////////////////////////////////////
	// Mode selection
	assign low_power = (mode_q == M_STANDBY) || (mode_q == M_GOSLEEP) ||
		(mode_q == M_SLEEP);
	assign wake_ev = low_power && (local_wake_hit || bus_wake_hit);

	always @* begin
		case ({standby_n_ctrl, mode_ctrl_hi})
		2'b11: mode_d = M_NORMAL;
		2'b10: mode_d = M_RECEIVE_ONLY_MODE;
		2'b01: mode_d = M_GOSLEEP;
		default: mode_d = M_STANDBY;
		endcase
		if (mode_q == M_SLEEP && mode_d == M_STANDBY && !wake_ev)
			mode_d = M_SLEEP;
		if (mode_q == M_SLEEP && wake_ev)
			mode_d = M_STANDBY;
		if (((mode_q == M_GOSLEEP && sleep_hold_hit) || mode_q == M_SLEEP) &&
			mode_d == M_GOSLEEP)
			mode_d = M_SLEEP;
		if (logic_uv_hit)
			mode_d = M_SLEEP;
		if (battery_uv_in)
			mode_d = M_STANDBY;
	end

	assign enter_normal = (mode_d == M_NORMAL) && (mode_q != M_NORMAL);
	assign rx_to_normal = (mode_d == M_NORMAL) && (mode_q == M_RECEIVE_ONLY_MODE);
	assign r2d = tx_q && !tx_in;
	assign d2r = !tx_q && tx_in;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_q <= M_STANDBY;
			tx_q <= 1'b1;
			wk_ref_q <= 1'b0;
		end else begin
			mode_q <= mode_d;
			tx_q <= tx_in;
			if (local_wake_hit)
				wk_ref_q <= local_wake_in;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Power-up, wake and undervoltage flags
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pwr_up_q <= 1'b1;
			wake_q <= 1'b0;
			wake_src_q <= 1'b0;
			src_edges_q <= 3'h0;
			luv_q <= 1'b0;
			buv_q <= 1'b0;
		end else begin
			if (enter_normal)
				pwr_up_q <= 1'b0;
			if (wake_ev)
				wake_q <= 1'b1;
			else if (mode_d == M_RECEIVE_ONLY_MODE || mode_d == M_NORMAL)
				wake_q <= 1'b0;
			if (enter_normal)
				src_edges_q <= 3'h0;
			else if (mode_q == M_NORMAL && r2d && src_edges_q != `CTD_EDGE_LIMIT)
				src_edges_q <= src_edges_q + 3'h1;
			if (wake_ev && local_wake_hit)
				wake_src_q <= 1'b1;
			else if (wake_ev)
				wake_src_q <= 1'b0;
			else if (mode_q == M_NORMAL && mode_d != M_NORMAL)
				wake_src_q <= 1'b0;
			else if (mode_q == M_NORMAL && r2d &&
				src_edges_q == `CTD_EDGE_LIMIT - 3'h1)
				wake_src_q <= 1'b0;
			if (logic_uv_hit)
				luv_q <= 1'b1;
			else if (pwr_up_q || wake_ev)
				luv_q <= 1'b0;
			if (battery_uv_in)
				buv_q <= 1'b1;
			else
				buv_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Bus failure: a dominant bit that never reaches the bus
	assign drive_ok = (mode_q == M_NORMAL) && !tx_blk_q && !ot_blk_q && txen_q;
	assign bit_fail = in_bit_q && !dom_seen_q && !bus_dominant_in;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			in_bit_q <= 1'b0;
			dom_seen_q <= 1'b0;
			fail_cnt_q <= 3'h0;
			ok_cnt_q <= 3'h0;
			bus_fail_q <= 1'b0;
		end else begin
			if (r2d && drive_ok) begin
				in_bit_q <= 1'b1;
				dom_seen_q <= 1'b0;
			end else if (d2r || !drive_ok) begin
				in_bit_q <= 1'b0;
			end else if (in_bit_q && bus_dominant_in) begin
				dom_seen_q <= 1'b1;
			end
			if (enter_normal) begin
				fail_cnt_q <= 3'h0;
				ok_cnt_q <= 3'h0;
				bus_fail_q <= 1'b0;
			end else if (d2r && in_bit_q) begin
				if (bit_fail) begin
					ok_cnt_q <= 3'h0;
					if (fail_cnt_q == `CTD_EDGE_LIMIT - 3'h1)
						bus_fail_q <= 1'b1;
					else
						fail_cnt_q <= fail_cnt_q + 3'h1;
				end else begin
					fail_cnt_q <= 3'h0;
					if (ok_cnt_q == `CTD_EDGE_LIMIT - 3'h1) begin
						ok_cnt_q <= 3'h0;
						bus_fail_q <= 1'b0;
					end else begin
						ok_cnt_q <= ok_cnt_q + 3'h1;
					end
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Local failures and transmitter blocking
	assign rx_int = !bus_dominant_in;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			loc_fail_q <= 1'b0;
			tx_blk_q <= 1'b0;
			ot_blk_q <= 1'b0;
			ot_seen_q <= 1'b0;
		end else begin
			if (tx_timeout || rx_clamp_hit || short_hit || bus_dom_timeout ||
				overtemp_in)
				loc_fail_q <= 1'b1;
			else if (rx_to_normal || (!rx_pin_in && tx_in && !short_hit))
				loc_fail_q <= 1'b0;
			if (tx_timeout || short_hit)
				tx_blk_q <= 1'b1;
			else if (rx_to_normal)
				tx_blk_q <= 1'b0;
			if (overtemp_in) begin
				ot_blk_q <= 1'b1;
				ot_seen_q <= 1'b0;
			end else if (ot_blk_q && !tx_in) begin
				ot_seen_q <= 1'b1;
			end else if (ot_blk_q && ot_seen_q && tx_in) begin
				ot_blk_q <= 1'b0;
				ot_seen_q <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pin outputs
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_out <= 1'b1;
			error_flag_out <= 1'b1;
			bus_drive_out <= 1'b0;
			split_en_out <= 1'b0;
			regulator_inhibit_out <= 1'b1;
			regulator_inhibit_oe <= 1'b1;
		end else begin
			case (mode_q)
			M_NORMAL: begin
				rx_out <= rx_int;
				error_flag_out <= !(bus_fail_q || (wake_src_q && !pwr_up_q));
				split_en_out <= 1'b1;
			end
			M_RECEIVE_ONLY_MODE: begin
				rx_out <= rx_int;
				error_flag_out <= !(pwr_up_q || loc_fail_q);
				split_en_out <= 1'b1;
			end
			default: begin
				rx_out <= !wake_q;
				error_flag_out <= !wake_q;
				split_en_out <= 1'b0;
			end
			endcase
			bus_drive_out <= drive_ok && !tx_in && !rx_clamp_hit;
			regulator_inhibit_out <= 1'b1;
			regulator_inhibit_oe <= (mode_q != M_SLEEP);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// APB slave
	assign pready = 1'b1;
	assign pslverr = psel && penable &&
		(paddr != `CTD_CTRL_OFF) && (paddr != `CTD_STATUS_OFF);

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			txen_q <= 1'b1;
			prdata <= 32'h00000000;
		end else begin
			if (psel && penable && pwrite && paddr == `CTD_CTRL_OFF)
				txen_q <= pwdata[`CTD_CTRL_TXEN_BIT];
			if (psel && !penable) begin
				prdata <= 32'h00000000;
				if (paddr == `CTD_CTRL_OFF)
					prdata[`CTD_CTRL_TXEN_BIT] <= txen_q;
				else if (paddr == `CTD_STATUS_OFF) begin
					prdata[`CTD_ST_MODE_LSB+2:`CTD_ST_MODE_LSB] <= mode_q;
					prdata[`CTD_ST_PWRUP_BIT] <= pwr_up_q;
					prdata[`CTD_ST_WAKE_BIT] <= wake_q;
					prdata[`CTD_ST_WSRC_BIT] <= wake_src_q;
					prdata[`CTD_ST_BUSF_BIT] <= bus_fail_q;
					prdata[`CTD_ST_LOCF_BIT] <= loc_fail_q;
					prdata[`CTD_ST_LUV_BIT] <= luv_q;
					prdata[`CTD_ST_BUV_BIT] <= buv_q;
					prdata[`CTD_ST_TXBLK_BIT] <= tx_blk_q;
					prdata[`CTD_ST_OTBLK_BIT] <= ot_blk_q;
				end
			end
		end
	end
endmodule

// *** ctd_host_mdl.sv ***
`timescale 1ns/1ns
module ctd_host_mdl (
	input wire pclk,
	output reg tx_in,
	output reg mode_ctrl_hi,
	output reg standby_n_ctrl
);
	initial begin
		tx_in = 1'b1;
		mode_ctrl_hi = 1'b0;
		standby_n_ctrl = 1'b0;
	end
	////////////////////////////////////////
	// Mode pins as {standby_n, hi}, then settle
	task set_mode(input logic [1:0] m);
		begin
			@(posedge pclk);
			{standby_n_ctrl, mode_ctrl_hi} <= m;
			repeat (4) @(posedge pclk);
		end
	endtask
	task send_bits(input int n, input int dom);
		begin
			repeat (n) begin
				@(posedge pclk);
				tx_in <= 1'b0;
				repeat (dom) @(posedge pclk);
				tx_in <= 1'b1;
				repeat (4) @(posedge pclk);
			end
		end
	endtask
endmodule

// *** ctd_mode_diag_props.sv ***
`timescale 1ns/1ns
module ctd_mode_diag_props #(
	parameter [15:0] SLEEP_HOLD_CYC = 16'h0008
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire [7:0] paddr,
	input wire pslverr,
	input wire mode_ctrl_hi,
	input wire standby_n_ctrl,
	input wire battery_uv_in,
	input wire rx_out,
	input wire error_flag_out,
	input wire bus_drive_out,
	input wire split_en_out,
	input wire regulator_inhibit_out,
	input wire regulator_inhibit_oe
);
	localparam [15:0] HOLD_LIM = SLEEP_HOLD_CYC + 16'h0005;
	wire sel_n = standby_n_ctrl & mode_ctrl_hi & ~battery_uv_in;
	wire sel_r = standby_n_ctrl & ~mode_ctrl_hi & ~battery_uv_in;
	wire sel_s = ~standby_n_ctrl & ~mode_ctrl_hi;
	wire sel_g = ~standby_n_ctrl & mode_ctrl_hi & ~battery_uv_in;
	wire mapped = (paddr == 8'h00) | (paddr == 8'h04);
	reg [15:0] gts_cnt_q;
	wire [15:0] gts_cnt_d = sel_g ? gts_cnt_q + 16'h0001 : 16'h0000;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) gts_cnt_q <= 16'h0000;
		else gts_cnt_q <= gts_cnt_d;
	end
	////////////////////////////////////////
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	a_inh_high: assert property (regulator_inhibit_out)
		else $error("inhibit not high");
	a_split_normal: assert property (sel_n [*3] |-> split_en_out)
		else $error("split off in normal");
	a_split_receive_only_mode: assert property (sel_r [*3] |-> split_en_out && !bus_drive_out)
		else $error("receive-only wrong");
	a_split_lowpwr: assert property (sel_s [*3] |-> !split_en_out)
		else $error("split on in standby");
	a_wake_pair: assert property (sel_s [*3] |-> rx_out == error_flag_out)
		else $error("wake outputs differ");
	a_drive_normal: assert property (bus_drive_out |-> $past(sel_n, 2))
		else $error("drive outside normal");
	a_sleep_pins: assert property (!regulator_inhibit_oe |-> $past(!standby_n_ctrl, 2))
		else $error("sleep with standby_n high");
	a_sleep_entry: assert property (gts_cnt_q == HOLD_LIM |-> !regulator_inhibit_oe)
		else $error("no sleep after hold");
	a_slverr_bad: assert property (psel && penable && !mapped |-> pslverr)
		else $error("unmapped not refused");
	a_slverr_ok: assert property (psel && penable && mapped |-> !pslverr)
		else $error("mapped refused");
	c_wake: cover property (sel_s && !error_flag_out);
	c_sleep: cover property (!regulator_inhibit_oe);
	c_refuse: cover property (psel && penable && pslverr);
endmodule
bind ctd_mode_diag ctd_mode_diag_props #(.SLEEP_HOLD_CYC(SLEEP_HOLD_CYC)) ctd_mode_diag_props_inst (
	.pclk(pclk),
	.presetn(presetn),
	.psel(psel),
	.penable(penable),
	.paddr(paddr),
	.pslverr(pslverr),
	.mode_ctrl_hi(mode_ctrl_hi),
	.standby_n_ctrl(standby_n_ctrl),
	.battery_uv_in(battery_uv_in),
	.rx_out(rx_out),
	.error_flag_out(error_flag_out),
	.bus_drive_out(bus_drive_out),
	.split_en_out(split_en_out),
	.regulator_inhibit_out(regulator_inhibit_out),
	.regulator_inhibit_oe(regulator_inhibit_oe)
);

// *** tb_top.sv ***
`timescale 1ns/1ns
module tb_top;
	reg pclk = 1'b0;
	reg presetn = 1'b0;
	reg psel = 1'b0;
	reg penable = 1'b0;
	reg pwrite = 1'b0;
	reg [7:0] paddr = 8'h00;
	reg [31:0] pwdata = 32'h00000000;
	reg local_wake_in = 1'b0;
	reg overtemp_in = 1'b0;
	reg battery_uv_in = 1'b0;
	reg bus_short = 1'b0;
	reg bus_stuck = 1'b0;
	reg serr;
	reg [31:0] rd;
	int n_fail = 0;
	int n_checks = 0;
	wire [31:0] prdata;
	wire pready, pslverr, tx_in, mode_ctrl_hi, standby_n_ctrl, rx_out, error_flag_out;
	wire bus_drive_out, split_en_out, regulator_inhibit_out, regulator_inhibit_oe;
	reg logic_uv_in = 1'b0;
	reg rx_pin_hi = 1'b0;
	reg tx_rx_short = 1'b0;
	// Receive pin follows the receive output unless pulled high or shorted to transmit
	wire rx_pin_in = rx_pin_hi | (rx_out & (tx_in | ~tx_rx_short));
	wire bus_dominant_in = (bus_drive_out & ~bus_short) | bus_stuck;
	wire [31:0] pins = {28'h0000000, regulator_inhibit_oe, split_en_out, rx_out, error_flag_out};
	ctd_host_mdl ctd_host_mdl_inst (
		.pclk(pclk),
		.tx_in(tx_in),
		.mode_ctrl_hi(mode_ctrl_hi),
		.standby_n_ctrl(standby_n_ctrl)
	);
	ctd_mode_diag #(
		.TXD_TIMEOUT_CYC(16'h0008),
		.BUS_DOM_TIMEOUT_CYC(16'h0008),
		.LOCAL_WAKE_FILTER_CYC(16'h0008),
		.BUS_WAKE_FILTER_CYC(16'h0008),
		.LOGIC_UV_FILTER_CYC(16'h0008),
		.SLEEP_HOLD_CYC(16'h0008),
		.RX_CLAMP_CYC(16'h0004),
		.SHORT_CYC(16'h0008)
	) ctd_mode_diag_inst (
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.mode_ctrl_hi(mode_ctrl_hi),
		.standby_n_ctrl(standby_n_ctrl),
		.tx_in(tx_in),
		.rx_pin_in(rx_pin_in),
		.bus_dominant_in(bus_dominant_in),
		.local_wake_in(local_wake_in),
		.overtemp_in(overtemp_in),
		.logic_uv_in(logic_uv_in),
		.battery_uv_in(battery_uv_in),
		.rx_out(rx_out),
		.error_flag_out(error_flag_out),
		.bus_drive_out(bus_drive_out),
		.split_en_out(split_en_out),
		.regulator_inhibit_out(regulator_inhibit_out),
		.regulator_inhibit_oe(regulator_inhibit_oe)
	);
	////////////////////////////////////////
	task check(input logic [31:0] seen, input logic [31:0] exp);
		begin
			n_checks++;
			if (seen !== exp) begin
				n_fail++;
				$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
			end
		end
	endtask
	task idle(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		begin
			@(posedge pclk);
			psel <= 1'b1;
			pwrite <= wr;
			paddr <= a;
			pwdata <= d;
			@(posedge pclk);
			penable <= 1'b1;
			@(posedge pclk);
			while (!pready) @(posedge pclk);
			rd = prdata;
			serr = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask
	task stat(input logic [31:0] m, input logic [31:0] e);
		begin
			apb(1'b0, 8'h04, 32'h00000000);
			check(rd & m, e);
		end
	endtask
	task pulse;
		begin
			bus_stuck <= 1'b1;
			idle(2);
			bus_stuck <= 1'b0;
			idle(4);
		end
	endtask
	task close_out;
		begin
			$display("checks %0d mismatches %0d", n_checks, n_fail);
			if (n_fail == 0 && n_checks > 0) $display("RESULT: PASS");
			else $display("RESULT: FAIL");
			$finish;
		end
	endtask
	////////////////////////////////////////
	initial begin
		forever #25 pclk = ~pclk;
	end
	initial begin
		repeat (20000) @(posedge pclk);
		n_fail++;
		close_out;
	end
	initial begin
		idle(6);
		presetn <= 1'b1;
		stat(32'h00000FFF, 32'h0000000A);
		check(pins, 32'h0000000B);
		apb(1'b0, 8'h00, 32'h00000000);
		check(rd, 32'h00000001);
		apb(1'b1, 8'h00, 32'h00000000);
		apb(1'b0, 8'h00, 32'h00000000);
		check(rd, 32'h00000000);
		apb(1'b1, 8'h00, 32'h00000001);
		apb(1'b0, 8'h08, 32'h00000000);
		check({rd[30:0], serr}, 32'h00000001);
		local_wake_in <= 1'b1;
		idle(12);
		check(pins, 32'h00000008);
		ctd_host_mdl_inst.set_mode(2'b10);
		check(pins, 32'h0000000E);
		stat(32'h00000010, 32'h00000000);
		ctd_host_mdl_inst.set_mode(2'b11);
		check(pins, 32'h0000000E);
		stat(32'h00000038, 32'h00000020);
		ctd_host_mdl_inst.send_bits(4, 4);
		check(pins, 32'h0000000F);
		bus_short <= 1'b1;
		ctd_host_mdl_inst.send_bits(4, 4);
		check(pins, 32'h0000000E);
		bus_short <= 1'b0;
		ctd_host_mdl_inst.send_bits(4, 4);
		check(pins, 32'h0000000F);
		ctd_host_mdl_inst.send_bits(1, 20);
		stat(32'h000004C0, 32'h00000480);
		check(pins, 32'h0000000F);
		ctd_host_mdl_inst.set_mode(2'b10);
		check(pins, 32'h0000000E);
		pulse;
		check(pins, 32'h0000000F);
		overtemp_in <= 1'b1;
		idle(4);
		check(pins, 32'h0000000E);
		overtemp_in <= 1'b0;
		pulse;
		check(pins, 32'h0000000F);
		ctd_host_mdl_inst.set_mode(2'b11);
		stat(32'h00000C80, 32'h00000800);
		ctd_host_mdl_inst.send_bits(1, 4);
		stat(32'h00000800, 32'h00000000);
		ctd_host_mdl_inst.set_mode(2'b10);
		bus_stuck <= 1'b1;
		idle(14);
		check(pins, 32'h0000000C);
		bus_stuck <= 1'b0;
		ctd_host_mdl_inst.set_mode(2'b11);
		stat(32'h00000080, 32'h00000000);
		ctd_host_mdl_inst.set_mode(2'b10);
		rx_pin_hi <= 1'b1;
		bus_stuck <= 1'b1;
		idle(7);
		bus_stuck <= 1'b0;
		idle(4);
		rx_pin_hi <= 1'b0;
		check(pins, 32'h0000000E);
		stat(32'h00000080, 32'h00000080);
		pulse;
		check(pins, 32'h0000000F);
		tx_rx_short <= 1'b1;
		ctd_host_mdl_inst.send_bits(1, 20);
		tx_rx_short <= 1'b0;
		check(pins, 32'h0000000E);
		stat(32'h00000480, 32'h00000480);
		ctd_host_mdl_inst.set_mode(2'b11);
		stat(32'h00000480, 32'h00000000);
		battery_uv_in <= 1'b1;
		idle(4);
		stat(32'h00000207, 32'h00000202);
		check(pins, 32'h0000000B);
		battery_uv_in <= 1'b0;
		idle(4);
		stat(32'h00000207, 32'h00000000);
		ctd_host_mdl_inst.set_mode(2'b01);
		idle(14);
		check(pins, 32'h00000003);
		ctd_host_mdl_inst.set_mode(2'b00);
		stat(32'h00000007, 32'h00000004);
		local_wake_in <= 1'b0;
		idle(12);
		check(pins, 32'h00000008);
		stat(32'h00000007, 32'h00000002);
		logic_uv_in <= 1'b1;
		idle(12);
		check(pins, 32'h00000000);
		stat(32'h00000107, 32'h00000104);
		logic_uv_in <= 1'b0;
		local_wake_in <= 1'b1;
		idle(12);
		stat(32'h00000107, 32'h00000002);
		ctd_host_mdl_inst.set_mode(2'b10);
		ctd_host_mdl_inst.set_mode(2'b00);
		bus_stuck <= 1'b1;
		idle(12);
		bus_stuck <= 1'b0;
		check(pins, 32'h00000008);
		ctd_host_mdl_inst.set_mode(2'b11);
		check(pins, 32'h0000000F);
		stat(32'h00000030, 32'h00000000);
		close_out;
	end
endmodule
